// ==== bench/epo_mcu_counter.sv ====
// Microcontroller model: counts calibration pulses over a timed window
`timescale 1ns/10ps
module epo_mcu_counter #(
    parameter int unsigned WIN_CYC = 20000
) (
    input  wire logic        ref_clk_in,
    input  wire logic        resetn_in,
    input  wire logic        pulse_in,
    input  wire logic        start_in,
    output logic      [15:0] count_out,
    output logic             done_out
);
    logic [31:0] timer;
    logic        pulse_q;

    // Own timer gates the count; short windows trade ripple for rate
    always_ff @(posedge ref_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            timer     <= '0;
            count_out <= '0;
            done_out  <= 1'b0;
            pulse_q   <= 1'b0;
        end else begin
            pulse_q <= pulse_in;
            if (start_in) begin
                timer     <= WIN_CYC;
                count_out <= '0;
                done_out  <= 1'b0;
            end else if (timer != 0) begin
                timer <= timer - 1;
                if (pulse_in && !pulse_q) begin
                    count_out <= count_out + 16'h1;
                end
                done_out <= (timer == 1);
            end
        end
    end
endmodule

// ==== bench/epo_pulse_out_bench.sv ====
// Self-checking bench for the energy pulse output stage
`timescale 1ns/10ps
module epo_pulse_out_bench;
    localparam int CF  = 1000;
    localparam int WIN = 20000;
    logic               clk;
    logic               resetn;
    logic signed [15:0] power;
    logic        [15:0] cur_mag;
    logic               v_bad;
    logic               fast_scale_select;
    logic               s_lo;
    logic               s_hi;
    logic               wr;
    logic               rd;
    logic               start;
    logic        [3:0]  addr;
    logic        [31:0] wdata;
    logic        [31:0] rdata;
    logic               calib;
    logic               rev;
    logic               fault;
    logic               irq;
    logic               drv_a;
    logic               drv_b;
    logic               done;
    logic        [15:0] mcu_cnt;
    logic               c_q;
    logic               f_q;
    int                 fail_count;
    int                 checks_done;
    int                 cyc;
    int                 rise_t;
    int                 per;
    int                 wid;
    int                 n_rise;

    epo_pulse_out #(.CF_CYC(CF), .DRV_CYC(20)) i_dut (
        .ref_clk_in(clk), .resetn_in(resetn), .power_in(power),
        .current_mag_in(cur_mag), .voltage_bad_in(v_bad),
        .fast_scale_select_in(fast_scale_select), .freq_select_lo_in(s_lo),
        .freq_select_hi_in(s_hi), .reg_addr_in(addr),
        .reg_wdata_in(wdata), .reg_write_in(wr), .reg_read_in(rd),
        .reg_rdata_out(rdata), .calib_pulse_out(calib),
        .meter_drive_a_out(drv_a), .meter_drive_b_out(drv_b),
        .reverse_power_flag_out(rev), .fault_flag_out(fault),
        .irq_out(irq));

    epo_mcu_counter #(.WIN_CYC(WIN)) i_mcu (
        .ref_clk_in(clk), .resetn_in(resetn), .pulse_in(calib),
        .start_in(start), .count_out(mcu_cnt), .done_out(done));

    // Clock, 20 ns period
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    task automatic summarize();
        $display("Checks %0d, failures %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic chk(input logic ok, input string msg);
        checks_done++;
        if (ok !== 1'b1) begin
            fail_count++;
            $display("[FAIL] %0t %s", $time, msg);
        end
    endtask

    // Full-scale accumulation per calibration pulse in fast mode
    function automatic longint thr();
        thr = longint'(epo_pkg::CLK_HZ) * 64'h64 * 64'h8000
            / longint'(16'h0546) / longint'(12'h800);
    endfunction

    task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr    <= 1'b0;
    endtask

    task automatic reg_rd(input logic [3:0] a, output logic [31:0] d);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd   <= 1'b0;
        #1 d = rdata;
        // Return on an edge so callers drive inputs at the clock
        @(posedge clk);
    endtask

    task automatic wait_rise(input int n);
        int tgt;
        int t;
        tgt = n_rise + n;
        t = 0;
        while (n_rise < tgt && t < 6000 * n) begin
            @(posedge clk);
            t++;
        end
        chk(n_rise >= tgt, "calibration pulse missing");
    endtask

    // Settle, then measure one steady period and the width after it
    task automatic check_rate(input int mag);
        int lo;
        int w;
        lo = int'(thr() / mag);
        wait_rise(3);
        chk(per >= lo && per <= lo + 1, "pulse period");
        repeat (CF + 2) @(posedge clk);
        w = (per < 2 * CF) ? per / 2 : CF;
        chk(wid >= w - 1 && wid <= w + 1, "pulse width");
    endtask

    // Edge monitor; the reverse flag may only move with a new pulse
    always @(posedge clk) begin
        cyc++;
        if (resetn && rev !== f_q && !(calib && !c_q)) begin
            chk(1'b0, "reverse flag moved off pulse");
        end
        if (calib === 1'b1 && !c_q) begin
            per = cyc - rise_t;
            rise_t = cyc;
            n_rise++;
        end
        if (calib === 1'b0 && c_q) begin
            wid = cyc - rise_t;
        end
        c_q = calib;
        f_q = rev;
    end

    // Watchdog: slowest path is about 75k cycles, keep under 100k
    initial begin
        repeat (95000) @(posedge clk);
        fail_count++;
        $display("[FAIL] %0t watchdog expired", $time);
        summarize();
    end

    initial begin
        logic [31:0] d;
        int          m;
        logic        sgn;
        {fail_count, checks_done, cyc, rise_t, per, wid, n_rise} = '0;
        {c_q, f_q, v_bad, fast_scale_select, s_lo, s_hi, wr, rd, start} = '0;
        resetn  = 1'b0;
        power   = 16'h0;
        cur_mag = 16'h0;
        addr    = 4'h0;
        wdata   = 32'h0;
        void'($urandom(32'hB298));
        repeat (16) @(posedge clk);
        chk({calib, drv_a, drv_b, rev, irq} === 5'h0, "reset outputs");
        resetn <= 1'b1;
        reg_rd(epo_pkg::REG_CTRL, d);
        chk(d === 32'h1, "control reset value");
        reg_rd(epo_pkg::REG_MASK, d);
        chk(d === 32'h0, "mask reset value");
        reg_wr(epo_pkg::REG_COUNT, 32'h55);
        reg_rd(epo_pkg::REG_COUNT, d);
        chk(d === 32'h0, "count reset or written");
        reg_rd(4'hF, d);
        chk(d === 32'h0, "unmapped read");
        // Every select combination at the smallest load
        for (int i = 0; i < 8; i++) begin
            fast_scale_select   <= i[2];
            s_hi  <= i[1];
            s_lo  <= i[0];
            power <= 16'sh1;
            repeat (4) @(posedge clk);
            reg_rd(epo_pkg::REG_STATE, d);
            chk(d[5] === (i == 3), "fast mode decode");
            chk(d[4] === (i != 3), "creep floor");
        end
        power <= 16'sh2;
        repeat (4) @(posedge clk);
        reg_rd(epo_pkg::REG_STATE, d);
        chk(d[4] === 1'b0, "creep floor boundary");
        {fast_scale_select, s_hi, s_lo} <= 3'h3;
        power <= -16'sh7FFF;
        check_rate(32767);
        chk(rev === 1'b1, "negative power flag");
        reg_rd(epo_pkg::REG_STATUS, d);
        chk(d[0] === 1'b1 && irq === 1'b0, "masked interrupt");
        reg_wr(epo_pkg::REG_MASK, 32'h1);
        @(posedge clk);
        #1 chk(irq === 1'b1, "interrupt raised");
        // Stop pulses first, a late set would win over the clear
        power <= 16'sh0;
        @(posedge clk);
        reg_wr(epo_pkg::REG_STATUS, 32'h1);
        repeat (2) @(posedge clk);
        #1 chk(irq === 1'b0, "interrupt cleared");
        power <= 16'sh4000;
        check_rate(16384);
        chk(rev === 1'b0, "positive power flag");
        // Random loads and signs in fast mode
        for (int k = 0; k < 2; k++) begin
            m = $urandom_range(32767, 16000);
            sgn = 1'($urandom_range(1, 0));
            power <= sgn ? 16'(-m) : 16'(m);
            check_rate(m);
            chk(rev === sgn, "random sign flag");
        end
        power <= 16'sh7FFF;
        wait_rise(1);
        start <= 1'b1;
        @(posedge clk);
        start <= 1'b0;
        repeat (WIN + 4) @(posedge clk);
        m = int'(longint'(WIN) * 32767 / thr());
        chk(done === 1'b1 && mcu_cnt >= m && mcu_cnt <= m + 1,
            "window pulse count");
        power <= -16'sh7FFF;
        wait_rise(2);
        @(posedge clk);
        v_bad   <= 1'b1;
        cur_mag <= 16'h7FFF;
        power   <= 16'sh0;
        @(posedge clk);
        #1 chk(fault === 1'b1, "fault flag");
        check_rate(32767);
        chk(rev === 1'b0, "reverse flag in fault mode");
        resetn <= 1'b0;
        repeat (2) @(posedge clk);
        chk({calib, drv_a, drv_b, rev, irq} === 5'h0, "second reset");
        summarize();
    end
endmodule

// ==== verilog/epo_pkg.sv ====
// Constants shared by the energy pulse output stage
package epo_pkg;

    // Device clock
    localparam int unsigned CLK_HZ        = 50_000_000;
    localparam int unsigned CYC_PER_MS    = CLK_HZ / 1000;

    // Calibration pulse timing
    localparam int unsigned CF_PULSE_MS   = 90;
    localparam int unsigned CF_SHORT_MS   = 180;
    localparam int unsigned CF_PULSE_CYC  = CF_PULSE_MS * CYC_PER_MS;
    localparam int unsigned CF_SHORT_CYC  = CF_SHORT_MS * CYC_PER_MS;

    // Counter-drive pulse width, a plain default
    localparam int unsigned DRV_PULSE_MS  = 90;
    localparam int unsigned DRV_PULSE_CYC = DRV_PULSE_MS * CYC_PER_MS;

    // Power sample width and full scale magnitude
    localparam int unsigned POWER_W       = 16;
    localparam longint unsigned FULL_SCALE = 64'h0000_0000_0000_8000;

    // Base frequencies in hundredths of a hertz, codes 00..11
    localparam logic [15:0] BASE_CHZ_00   = 16'h00AC;   // 1.72 Hz
    localparam logic [15:0] BASE_CHZ_01   = 16'h0158;   // 3.44 Hz
    localparam logic [15:0] BASE_CHZ_10   = 16'h02AE;   // 6.86 Hz
    localparam logic [15:0] BASE_CHZ_11   = 16'h0546;   // 13.5 Hz

    // Calibration to counter-drive ratio
    localparam logic [11:0] RATIO_FAST    = 12'h800;    // 2048
    localparam logic [11:0] RATIO_NORM    = 12'h040;    // 64

    // Creep floor, 0.0045 % of full scale, rounded up
    localparam longint unsigned CREEP_NUM = 45;
    localparam longint unsigned CREEP_DEN = 1_000_000;
    localparam logic [15:0] CREEP_MAG     =
        16'((FULL_SCALE * CREEP_NUM + CREEP_DEN - 1) / CREEP_DEN);

    // Accumulator width
    localparam int unsigned ACC_W         = 48;

    // Register map
    localparam int unsigned ADDR_W        = 4;
    localparam logic [3:0]  REG_CTRL      = 4'h0;
    localparam logic [3:0]  REG_STATUS    = 4'h1;
    localparam logic [3:0]  REG_MASK      = 4'h2;
    localparam logic [3:0]  REG_STATE     = 4'h3;
    localparam logic [3:0]  REG_COUNT     = 4'h4;
    localparam logic [0:0]  CTRL_RESET    = 1'h1;
    localparam logic [3:0]  MASK_RESET    = 4'h0;

    // Status bit positions
    localparam int unsigned ST_CF         = 0;
    localparam int unsigned ST_DRV        = 1;
    localparam int unsigned ST_REV        = 2;
    localparam int unsigned ST_FAULT      = 3;
    localparam int unsigned ST_W          = 4;

endpackage

// ==== verilog/epo_pulse_out.sv ====
// Energy pulse output stage: calibration and counter-drive pulses
//
// Chosen here: the plain strobed port and the register addresses.
`timescale 1ns/10ps
module epo_pulse_out #(
    parameter int unsigned PW      = epo_pkg::POWER_W,
    parameter int unsigned CF_CYC  = epo_pkg::CF_PULSE_CYC,
    parameter int unsigned DRV_CYC = epo_pkg::DRV_PULSE_CYC
) (
    input  wire logic                        ref_clk_in,
    input  wire logic                        resetn_in,
    input  wire logic signed [PW-1:0]        power_in,
    input  wire logic        [PW-1:0]        current_mag_in,
    input  wire logic                        voltage_bad_in,
    input  wire logic                        fast_scale_select_in,
    input  wire logic                        freq_select_lo_in,
    input  wire logic                        freq_select_hi_in,
    input  wire logic [epo_pkg::ADDR_W-1:0]  reg_addr_in,
    input  wire logic [31:0]                 reg_wdata_in,
    input  wire logic                        reg_write_in,
    input  wire logic                        reg_read_in,
    output logic      [31:0]                 reg_rdata_out,
    output logic                             calib_pulse_out,
    output logic                             meter_drive_a_out,
    output logic                             meter_drive_b_out,
    output logic                             reverse_power_flag_out,
    output logic                             fault_flag_out,
    output logic                             irq_out
);
    localparam int unsigned AW = epo_pkg::ACC_W;

    if (PW != epo_pkg::POWER_W) begin : g_bad_pw
        $error("Power width must match the full scale constant");
    end

    // Base frequency from the select pair
    function automatic logic [15:0] base_chz(input logic [1:0] sel);
        unique case (sel)
            2'b00: base_chz = epo_pkg::BASE_CHZ_00;
            2'b01: base_chz = epo_pkg::BASE_CHZ_01;
            2'b10: base_chz = epo_pkg::BASE_CHZ_10;
            2'b11: base_chz = epo_pkg::BASE_CHZ_11;
        endcase
    endfunction

    // Counter-drive threshold: clock * full scale / base frequency
    function automatic logic [AW-1:0] drive_thr(input logic [1:0] sel);
        logic [63:0] num;
        num = 64'(epo_pkg::CLK_HZ) * 64'h64 * epo_pkg::FULL_SCALE;
        drive_thr = AW'(num / 64'(base_chz(sel)));
    endfunction

    logic [1:0]    sel;
    logic          fast_mode;
    logic [11:0]   ratio;
    logic [AW-1:0] cf_thr;
    logic [PW-1:0] mag;
    logic          creep_block;
    logic          neg_now;

    // Mode decode and magnitude select
    always_comb begin
        sel       = {freq_select_hi_in, freq_select_lo_in};
        fast_mode = !fast_scale_select_in && (sel == 2'b11);
        ratio     = fast_mode ? epo_pkg::RATIO_FAST
                              : epo_pkg::RATIO_NORM;
        cf_thr    = AW'(drive_thr(sel) / AW'(ratio));
        neg_now   = power_in[PW-1];
        if (voltage_bad_in) begin
            mag = current_mag_in;
        end else if (neg_now) begin
            mag = PW'(-power_in);
        end else begin
            mag = PW'(power_in);
        end
        // Floor is a magnitude compare, so it also holds off accumulation
        creep_block = !fast_mode && (mag < epo_pkg::CREEP_MAG);
    end

    // Core state
    logic [AW-1:0] acc;
    logic [11:0]   div;
    logic          cf_trig;
    logic          drv_trig;
    logic          side;
    logic          cross_neg;
    logic          out_en;
    logic          fault_q;
    logic [15:0]   pulse_count;
    logic [AW-1:0] next_acc;
    logic [AW-1:0] sum;
    logic [11:0]   next_div;
    logic          next_cf_trig;
    logic          next_drv_trig;
    logic          next_side;
    logic          next_cross_neg;
    logic          next_rev;
    logic [15:0]   next_count;

    // Accumulate, cross, and divide down to the counter drive
    always_comb begin
        sum            = acc + AW'(mag);
        next_acc       = acc;
        next_div       = div;
        next_cf_trig   = 1'b0;
        next_drv_trig  = 1'b0;
        next_side      = side;
        next_cross_neg = cross_neg;
        next_rev       = reverse_power_flag_out;
        next_count     = pulse_count;
        if (cf_trig) begin
            next_rev   = cross_neg;
            next_count = 16'(pulse_count + 1'b1);
        end
        if (out_en && !creep_block) begin
            if (sum >= cf_thr) begin
                next_acc       = AW'(sum - cf_thr);
                next_cf_trig   = 1'b1;
                next_cross_neg = neg_now && !voltage_bad_in;
                // Pins alternate, so each pin gets one pulse per ratio
                // Select change may leave div above the new ratio
                if (div >= 12'((ratio >> 1) - 1'b1)) begin
                    next_div      = '0;
                    next_drv_trig = 1'b1;
                    next_side     = !side;
                end else begin
                    next_div = 12'(div + 1'b1);
                end
            end else begin
                next_acc = sum;
            end
        end
    end

    always_ff @(posedge ref_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            acc                    <= '0;
            div                    <= '0;
            cf_trig                <= 1'b0;
            drv_trig               <= 1'b0;
            side                   <= 1'b0;
            cross_neg              <= 1'b0;
            reverse_power_flag_out <= 1'b0;
            pulse_count            <= '0;
            fault_q                <= 1'b0;
            fault_flag_out         <= 1'b0;
        end else begin
            acc                    <= next_acc;
            div                    <= next_div;
            cf_trig                <= next_cf_trig;
            drv_trig               <= next_drv_trig;
            side                   <= next_side;
            cross_neg              <= next_cross_neg;
            reverse_power_flag_out <= next_rev;
            pulse_count            <= next_count;
            fault_q                <= voltage_bad_in;
            fault_flag_out         <= voltage_bad_in;
        end
    end

    // Pulse shapers; drive pulses alternate between the two pins
    logic [2:0] trig_vec;
    logic [2:0] pulse_vec;
    assign trig_vec = {drv_trig && side, drv_trig && !side, cf_trig};
    assign calib_pulse_out   = pulse_vec[0];
    assign meter_drive_a_out = pulse_vec[1];
    assign meter_drive_b_out = pulse_vec[2];

    for (genvar i = 0; i < 3; i++) begin : g_shape
        epo_pulse_shaper #(
            .MAX_CYC (i == 0 ? CF_CYC : DRV_CYC)
        ) u_shape (
            .ref_clk_in (ref_clk_in),
            .resetn_in  (resetn_in),
            .trig_in    (trig_vec[i]),
            .pulse_out  (pulse_vec[i])
        );
    end

    // Register file state
    logic [epo_pkg::ST_W-1:0] status;
    logic [epo_pkg::ST_W-1:0] mask;
    logic [epo_pkg::ST_W-1:0] events;
    logic [epo_pkg::ST_W-1:0] next_status;
    logic [epo_pkg::ST_W-1:0] next_mask;
    logic                     next_out_en;
    logic [31:0]              next_rdata;
    logic                     next_irq;

    // Bus decode; set wins over a write-one clear in the same cycle
    always_comb begin
        events = '0;
        events[epo_pkg::ST_CF]    = cf_trig;
        events[epo_pkg::ST_DRV]   = drv_trig;
        events[epo_pkg::ST_REV]   = cf_trig &&
                                    (cross_neg != reverse_power_flag_out);
        events[epo_pkg::ST_FAULT] = voltage_bad_in && !fault_q;
        next_status = status;
        next_mask   = mask;
        next_out_en = out_en;
        next_rdata  = '0;
        if (reg_write_in) begin
            unique case (reg_addr_in)
                epo_pkg::REG_CTRL:   next_out_en = reg_wdata_in[0];
                epo_pkg::REG_STATUS: next_status =
                    status & ~reg_wdata_in[epo_pkg::ST_W-1:0];
                epo_pkg::REG_MASK:   next_mask =
                    reg_wdata_in[epo_pkg::ST_W-1:0];
                default:             next_mask = mask;
            endcase
        end
        next_status = next_status | events;
        if (reg_read_in) begin
            unique case (reg_addr_in)
                epo_pkg::REG_CTRL:   next_rdata = {31'h0, out_en};
                epo_pkg::REG_STATUS: next_rdata = {28'h0, status};
                epo_pkg::REG_MASK:   next_rdata = {28'h0, mask};
                epo_pkg::REG_STATE:  next_rdata = {26'h0, fast_mode,
                    creep_block, sel, fault_q, reverse_power_flag_out};
                epo_pkg::REG_COUNT:  next_rdata = {16'h0, pulse_count};
                default:             next_rdata = '0;
            endcase
        end
        next_irq = |(next_status & next_mask);
    end

    always_ff @(posedge ref_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            status        <= '0;
            mask          <= epo_pkg::MASK_RESET;
            out_en        <= epo_pkg::CTRL_RESET[0];
            reg_rdata_out <= '0;
            irq_out       <= 1'b0;
        end else begin
            status        <= next_status;
            mask          <= next_mask;
            out_en        <= next_out_en;
            reg_rdata_out <= next_rdata;
            irq_out       <= next_irq;
        end
    end

    // Checks
    a_cf_cause: assert property (
        @(posedge ref_clk_in) disable iff (!resetn_in)
        $rose(calib_pulse_out) |-> $past(cf_trig))
        else $error("Calibration pulse without a crossing");

    a_creep_hold: assert property (
        @(posedge ref_clk_in) disable iff (!resetn_in)
        creep_block |=> !cf_trig && $stable(acc))
        else $error("Accumulation below the creep floor");

    a_creep_fast_off: assert property (
        @(posedge ref_clk_in) disable iff (!resetn_in)
        fast_mode |-> !creep_block)
        else $error("Creep floor active in fast mode");

    a_rev_only_cf: assert property (
        @(posedge ref_clk_in) disable iff (!resetn_in)
        !cf_trig |=> $stable(reverse_power_flag_out))
        else $error("Reverse flag moved without a pulse");

    a_rev_sign: assert property (
        @(posedge ref_clk_in) disable iff (!resetn_in)
        next_cf_trig && !voltage_bad_in |=> ##1
            reverse_power_flag_out == $past(neg_now, 2))
        else $error("Reverse flag does not follow power sign");

    a_fast_ratio: assert property (
        @(posedge ref_clk_in) disable iff (!resetn_in)
        fast_mode |-> ratio == 12'h800)
        else $error("Fast mode ratio is not 2048");

    a_drive_div: assert property (
        @(posedge ref_clk_in) disable iff (!resetn_in)
        next_drv_trig |-> next_cf_trig && div >= 12'((ratio >> 1) - 1'b1))
        else $error("Drive pulse not on ratio boundary");

    a_base_sel: assert property (
        @(posedge ref_clk_in) disable iff (!resetn_in)
        sel == 2'b00 |-> base_chz(sel) == 16'h00AC)
        else $error("Lowest base frequency wrong");

    a_fault_mag: assert property (
        @(posedge ref_clk_in) disable iff (!resetn_in)
        voltage_bad_in |-> mag == current_mag_in ##1 fault_flag_out)
        else $error("Fault mode does not use current magnitude");

    a_cf_width: assert property (
        @(posedge ref_clk_in) disable iff (!resetn_in)
        $rose(calib_pulse_out) |-> calib_pulse_out[*2])
        else $error("Calibration pulse shorter than two cycles");

    a_irq_level: assert property (
        @(posedge ref_clk_in) disable iff (!resetn_in)
        ##1 irq_out == |($past(next_status) & $past(next_mask)))
        else $error("Interrupt not following masked status");

endmodule

// ==== verilog/epo_pulse_shaper.sv ====
// Pulse stretcher: fixed width, or half the period when pulses come fast
`timescale 1ns/10ps
module epo_pulse_shaper #(
    parameter int unsigned MAX_CYC = 4_500_000
) (
    input  wire logic ref_clk_in,
    input  wire logic resetn_in,
    input  wire logic trig_in,
    output logic      pulse_out
);
    localparam int unsigned CW = $clog2(2 * MAX_CYC + 2);
    localparam logic [CW-1:0] SAT = CW'(2 * MAX_CYC);
    localparam logic [CW-1:0] MAXW = CW'(MAX_CYC);

    if (MAX_CYC < 2) begin : g_bad_width
        $error("Pulse width must be at least two cycles");
    end

    logic [CW-1:0] since;
    logic [CW-1:0] left;
    logic [CW-1:0] next_since;
    logic [CW-1:0] next_left;
    logic [CW-1:0] period;
    logic [CW-1:0] half;

    // Period since last trigger picks width: full width or half period
    always_comb begin
        period     = (since == SAT) ? SAT : CW'(since + 1'b1);
        half       = period >> 1;
        next_since = (since == SAT) ? SAT : CW'(since + 1'b1);
        next_left  = (left != '0) ? CW'(left - 1'b1) : left;
        if (trig_in) begin
            next_since = '0;
            if (half < MAXW) begin
                next_left = (half == '0) ? CW'(1) : half;
            end else begin
                next_left = MAXW;
            end
        end
    end

    // First pulse after reset sees a saturated period, so full width
    always_ff @(posedge ref_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            since     <= SAT;
            left      <= '0;
            pulse_out <= 1'b0;
        end else begin
            since     <= next_since;
            left      <= next_left;
            pulse_out <= (next_left != '0);
        end
    end

    a_width_bound: assert property (
        @(posedge ref_clk_in) disable iff (!resetn_in)
        left <= MAXW)
        else $error("Pulse counter above maximum width");

endmodule
